// [rtl/smf_pkg.sv]
// Shared constants and types of the secure memory serial front end.
package smf_pkg;
  localparam int          CLK_HZ    = 40_000_000;
  localparam int          ETU_CLKS  = 372;
  localparam logic [8:0]  ETU_LAST  = 9'(ETU_CLKS - 1);
  localparam logic [8:0]  ETU_HALF  = 9'(ETU_CLKS / 2 - 1);
  localparam logic [8:0]  ETU_ZERO  = 9'h000;
  localparam logic [8:0]  ETU_ONE   = 9'h001;
  localparam logic [3:0]  CHR_LAST  = 4'hB;
  localparam logic [3:0]  DATA_LAST = 4'h8;
  localparam logic [3:0]  PAR_BIT   = 4'h9;
  localparam logic [2:0]  ATR_LAST  = 3'h7;
  localparam logic [3:0]  BYTE_BITS = 4'h8;
  localparam logic [7:0]  RD_DENY   = 8'hFF;
  localparam int          T_WR_US   = 5000;
  localparam int          T_WR_CYC  = T_WR_US * (CLK_HZ / 1_000_000);
  localparam int          PROG_W    = 18;
  localparam int          PG_SIZE   = 16;
  localparam int          MEM_SIZE  = 256;
  localparam int          NPIN      = 4;
  localparam int          PIN_SCL   = 0;
  localparam int          PIN_SDA   = 1;
  localparam int          PIN_RST   = 2;
  localparam int          PIN_MODE  = 3;
  localparam logic [3:0]  PIN_IDLE  = 4'hF;
  typedef enum logic [2:0] {
    SMF_P_IDLE, SMF_P_DEV, SMF_P_ADDR, SMF_P_WR, SMF_P_RD
  } smf_sph_e;
  typedef enum logic [1:0] {SMF_A_IDLE, SMF_A_TX, SMF_A_RX} smf_aph_e;
endpackage

// [rtl/smf_front_end.sv]
// Pin front end of the secure memory: async character link and sync bus.
// Contract
// R1: async bit time lasts 372 periods of the supplied link clock.
// R2: sync mode samples data on clock rise, changes output after fall.
// R3: reset activation sends the 64-bit answer-to-reset serially, async framing; the code starts it on reset release (rising pin).
// R4: undriven reset input reads inactive through an internal pull-up.
// R5: no answer-to-reset is produced in sync mode.
// R6: data line is only pulled low or released, never driven high.
// R7: up to 15 devices share the bus; each answers its own address.
// R8: single byte or 16-byte page writes, finished by a timed programming cycle.
// R9: memory is four 64-byte zones, each with its own access rights.
// R10: host clocks the sync bus at no more than 1.0 MHz.
// R11: data changes only while clock low; high-time changes are start/stop.
// R12: falling data while clock high starts every sync command.
// R13: async receiver counts clocks and samples near each bit's middle.
`timescale 1ns/100ps
module smf_front_end #(
  parameter int          PROG_CYCLES = smf_pkg::T_WR_CYC,
  parameter logic [63:0] ATR_VALUE   = 64'h3B00_1122_3344_5566 // Arbitrary.
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_scl_clk,
  input  wire logic       i_sda_in,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  input  wire logic       i_rst_pad,
  input  wire logic       i_rst_pad_drv,
  input  wire logic       i_mode_sync,
  input  wire logic [3:0] i_dev_addr,
  input  wire logic [3:0] i_zone_wr_en,
  input  wire logic [3:0] i_zone_rd_en,
  output logic            o_busy,
  output logic            o_atr_done,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_perr
);
  // The pad sees a released reset pin as high.
  wire logic [3:0] pin_raw = {i_mode_sync, ~i_rst_pad_drv | i_rst_pad,
                              i_sda_in, i_scl_clk}; // R4
  logic [3:0] sy1_q;
  logic [3:0] sy2_q;
  logic [3:0] prv_q;

  // Two-flop synchronisers per pin; the second stage and a third, delayed copy of it feed logic.
  for (genvar g = 0; g < smf_pkg::NPIN; g++) begin : g_sync
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        sy1_q[g] <= smf_pkg::PIN_IDLE[g];
        sy2_q[g] <= smf_pkg::PIN_IDLE[g];
        prv_q[g] <= smf_pkg::PIN_IDLE[g];
      end else begin
        sy1_q[g] <= pin_raw[g];
        sy2_q[g] <= sy1_q[g];
        prv_q[g] <= sy2_q[g];
      end
    end
  end

  // Edge and bus condition decode on the synchronised pins.
  wire logic scl      = sy2_q[smf_pkg::PIN_SCL];
  wire logic sda      = sy2_q[smf_pkg::PIN_SDA];
  wire logic rstl     = sy2_q[smf_pkg::PIN_RST];
  wire logic sync_m   = sy2_q[smf_pkg::PIN_MODE];
  wire logic scl_rise = scl & ~prv_q[smf_pkg::PIN_SCL];
  wire logic scl_fall = ~scl & prv_q[smf_pkg::PIN_SCL];
  wire logic sda_fall = ~sda & prv_q[smf_pkg::PIN_SDA];
  wire logic sda_rise = sda & ~prv_q[smf_pkg::PIN_SDA];
  wire logic rst_rise = rstl & ~prv_q[smf_pkg::PIN_RST];
  wire logic hi_keep  = scl & prv_q[smf_pkg::PIN_SCL];
  wire logic cond_start = hi_keep & sda_fall; // R12
  wire logic cond_stop  = hi_keep & sda_rise; // R11

  smf_pkg::smf_sph_e s_ph_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  tx_q;
  logic [7:0]  addr_q;
  logic [3:0]  page_q;
  logic        s_oe_q;
  logic        ack_ph_q;
  logic        nack_q;
  logic        busy_q;
  logic [15:0] pg_v_q;
  logic [7:0]  pg_q [smf_pkg::PG_SIZE];
  logic [7:0]  mem_q [smf_pkg::MEM_SIZE];
  logic [smf_pkg::PROG_W-1:0] pcnt_q;

  // Zone rights come from the top two address bits.
  wire logic [1:0] zone    = addr_q[7:6];
  wire logic       zwr     = i_zone_wr_en[zone]; // R9
  wire logic       zrd     = i_zone_rd_en[zone]; // R9
  wire logic [7:0] rd_byte = zrd ? mem_q[addr_q] : smf_pkg::RD_DENY; // R9
  wire logic dev_hit  = (sh_q[7:4] == i_dev_addr) & ~busy_q; // R7
  wire logic byte_end = scl_fall & (cnt_q == smf_pkg::BYTE_BITS);
  wire logic ack_end  = scl_fall & ack_ph_q;
  wire logic pg_we    = byte_end & (s_ph_q == smf_pkg::SMF_P_WR) & zwr;
  wire logic prog_go  = cond_stop & (s_ph_q == smf_pkg::SMF_P_WR)
                        & (|pg_v_q) & ~busy_q; // R8
  wire logic prog_end = busy_q
                        & (pcnt_q == smf_pkg::PROG_W'(PROG_CYCLES - 1));

  // Bit capture on clock rise; the ninth rise samples the host's ack.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      nack_q <= 1'b0;
    end else if (cond_start) begin
      cnt_q <= 4'h0;
    end else if (scl_rise) begin // R2
      if (cnt_q == smf_pkg::BYTE_BITS) begin
        nack_q <= sda;
        cnt_q  <= 4'h0;
      end else begin
        sh_q  <= {sh_q[6:0], sda};
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // Command sequencer; output changes follow a falling clock, or a start, stop or sync mode exit that releases it.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_ph_q   <= smf_pkg::SMF_P_IDLE;
      s_oe_q   <= 1'b0;
      ack_ph_q <= 1'b0;
      addr_q   <= 8'h00;
      page_q   <= 4'h0;
      tx_q     <= 8'h00;
    end else if (!sync_m || cond_stop) begin // R11
      s_ph_q   <= smf_pkg::SMF_P_IDLE;
      s_oe_q   <= 1'b0;
      ack_ph_q <= 1'b0;
    end else if (cond_start) begin // R12
      s_ph_q   <= smf_pkg::SMF_P_DEV;
      s_oe_q   <= 1'b0;
      ack_ph_q <= 1'b0;
    end else if (byte_end) begin // R2
      ack_ph_q <= 1'b1;
      unique case (s_ph_q)
        smf_pkg::SMF_P_IDLE: s_oe_q <= 1'b0;
        smf_pkg::SMF_P_DEV: begin
          s_oe_q <= dev_hit; // R7
          if (!dev_hit) begin
            s_ph_q <= smf_pkg::SMF_P_IDLE;
          end else if (sh_q[0]) begin
            s_ph_q <= smf_pkg::SMF_P_RD;
          end else begin
            s_ph_q <= smf_pkg::SMF_P_ADDR;
          end
        end
        smf_pkg::SMF_P_ADDR: begin
          addr_q <= sh_q;
          page_q <= sh_q[7:4];
          s_oe_q <= 1'b1;
          s_ph_q <= smf_pkg::SMF_P_WR;
        end
        smf_pkg::SMF_P_WR: begin
          s_oe_q <= zwr; // R9
          // Page writes wrap inside the 16-byte page.
          addr_q <= {addr_q[7:4], addr_q[3:0] + 4'h1}; // R8
          if (!zwr) begin
            s_ph_q <= smf_pkg::SMF_P_IDLE;
          end
        end
        smf_pkg::SMF_P_RD: s_oe_q <= 1'b0;
      endcase
    end else if (ack_end) begin
      ack_ph_q <= 1'b0;
      s_oe_q   <= 1'b0;
      if (s_ph_q == smf_pkg::SMF_P_RD) begin
        if (nack_q) begin
          s_ph_q <= smf_pkg::SMF_P_IDLE;
        end else begin
          s_oe_q <= ~rd_byte[7]; // R6
          tx_q   <= {rd_byte[6:0], 1'b1};
          addr_q <= addr_q + 8'h01;
        end
      end
    end else if (scl_fall && s_ph_q == smf_pkg::SMF_P_RD) begin // R2
      s_oe_q <= ~tx_q[7]; // R6
      tx_q   <= {tx_q[6:0], 1'b1};
    end
  end

  // Page buffer entries; a new address byte starts an empty page.
  for (genvar g = 0; g < smf_pkg::PG_SIZE; g++) begin : g_page
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        pg_v_q[g] <= 1'b0;
      end else if (byte_end && s_ph_q == smf_pkg::SMF_P_ADDR) begin
        pg_v_q[g] <= 1'b0;
      end else if (pg_we && addr_q[3:0] == 4'(g)) begin // R8
        pg_v_q[g] <= 1'b1;
      end
    end
    always_ff @(posedge i_mclk) begin
      if (pg_we && addr_q[3:0] == 4'(g)) begin
        pg_q[g] <= sh_q;
      end
    end
  end

  // Programming timer; the device ignores its address until done.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      pcnt_q <= '0;
    end else if (prog_go) begin // R8
      busy_q <= 1'b1;
      pcnt_q <= '0;
    end else if (prog_end) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      pcnt_q <= pcnt_q + smf_pkg::PROG_W'(1);
    end
  end

  // Cells change only at the end of the timed cycle, all at once.
  always_ff @(posedge i_mclk) begin
    for (int i = 0; i < smf_pkg::PG_SIZE; i++) begin
      if (prog_end && pg_v_q[i]) begin // R8
        mem_q[{page_q, 4'(i)}] <= pg_q[i];
      end
    end
  end

  smf_pkg::smf_aph_e a_st_q;
  logic [8:0] etu_q;
  logic [3:0] bit_q;
  logic [2:0] chr_q;
  logic [8:0] rx_sh_q;
  logic       a_oe_q;

  // Character timing runs on link clock rises counted in the local domain.
  wire logic       etu_end  = scl_rise & (etu_q == smf_pkg::ETU_LAST); // R1
  wire logic       a_smp    = scl_rise & (etu_q == smf_pkg::ETU_HALF)
                              & (a_st_q == smf_pkg::SMF_A_RX); // R13
  wire logic       atr_go   = rst_rise & ~sync_m; // R5
  wire logic       rx_go    = (a_st_q == smf_pkg::SMF_A_IDLE) & sda_fall;
  wire logic [7:0] atr_byte = ATR_VALUE[{~chr_q, 3'h0} +: 8]; // R3
  wire logic [3:0] bit_m1   = bit_q - 4'h1;
  wire logic       tx_bit   = (bit_q == 4'h0) ? 1'b0 :
                              (bit_q <= smf_pkg::DATA_LAST) ?
                              atr_byte[bit_m1[2:0]] :
                              (bit_q == smf_pkg::PAR_BIT) ? ^atr_byte : 1'b1;
  wire logic [8:0] etu_nx   = etu_end ? smf_pkg::ETU_ZERO
                                      : etu_q + smf_pkg::ETU_ONE;

  // Async sequencer: answer-to-reset transmit and character receive.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_st_q     <= smf_pkg::SMF_A_IDLE;
      etu_q      <= smf_pkg::ETU_ZERO;
      bit_q      <= 4'h0;
      chr_q      <= 3'h0;
      rx_sh_q    <= 9'h000;
      o_atr_done <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data  <= 8'h00;
      o_rx_perr  <= 1'b0;
    end else begin
      o_atr_done <= 1'b0;
      o_rx_valid <= 1'b0;
      if (sync_m || !rstl) begin // R5
        a_st_q <= smf_pkg::SMF_A_IDLE;
      end else if (atr_go) begin // R3
        a_st_q <= smf_pkg::SMF_A_TX;
        etu_q  <= smf_pkg::ETU_ZERO;
        bit_q  <= 4'h0;
        chr_q  <= 3'h0;
      end else begin
        unique case (a_st_q)
          smf_pkg::SMF_A_IDLE: begin
            if (rx_go) begin
              a_st_q <= smf_pkg::SMF_A_RX;
              etu_q  <= smf_pkg::ETU_ZERO;
              bit_q  <= 4'h0;
            end
          end
          smf_pkg::SMF_A_TX: begin
            if (scl_rise) begin
              etu_q <= etu_nx; // R1
            end
            if (etu_end && bit_q == smf_pkg::CHR_LAST) begin
              bit_q <= 4'h0;
              chr_q <= chr_q + 3'h1;
              if (chr_q == smf_pkg::ATR_LAST) begin
                a_st_q     <= smf_pkg::SMF_A_IDLE;
                o_atr_done <= 1'b1;
              end
            end else if (etu_end) begin
              bit_q <= bit_q + 4'h1; // R1
            end
          end
          smf_pkg::SMF_A_RX: begin
            if (scl_rise) begin
              etu_q <= etu_nx; // R13
            end
            if (a_smp) begin // R13
              rx_sh_q <= {sda, rx_sh_q[8:1]};
              bit_q   <= bit_q + 4'h1;
              // A start bit that reads high was a glitch.
              if ((bit_q == 4'h0 && sda) || bit_q == smf_pkg::PAR_BIT) begin
                a_st_q <= smf_pkg::SMF_A_IDLE;
              end
              if (bit_q == smf_pkg::PAR_BIT) begin
                o_rx_valid <= 1'b1;
                o_rx_data  <= rx_sh_q[8:1];
                o_rx_perr  <= ^{rx_sh_q[8:1], sda};
              end
            end
          end
          default: a_st_q <= smf_pkg::SMF_A_IDLE;
        endcase
      end
    end
  end

  // Pin drivers: low or released only, one extra cycle of latency in sync mode, two in async mode.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_oe_q    <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_sda_out <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      a_oe_q    <= (a_st_q == smf_pkg::SMF_A_TX) & ~tx_bit; // R3
      o_sda_oe  <= sync_m ? s_oe_q : a_oe_q; // R6
      o_sda_out <= 1'b0; // R6
      o_busy    <= busy_q;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_r1;
    etu_end && a_st_q == smf_pkg::SMF_A_TX && rstl && !sync_m && !atr_go
      |=> bit_q != $past(bit_q);
  endproperty
  a_r1: assert property (p_r1) else $error("etu end did not step bit"); // R1
  property p_r13;
    a_st_q == smf_pkg::SMF_A_RX && $past(a_st_q) == smf_pkg::SMF_A_RX
      && bit_q != $past(bit_q) |-> $past(etu_q) == smf_pkg::ETU_HALF;
  endproperty
  a_r13: assert property (p_r13) else $error("rx sample off centre"); // R13
  property p_r3;
    atr_go && rstl |=> a_st_q == smf_pkg::SMF_A_TX && chr_q == 3'h0;
  endproperty
  a_r3: assert property (p_r3) else $error("reset gave no answer"); // R3
  property p_r5;
    a_st_q == smf_pkg::SMF_A_TX |-> !$past(sync_m);
  endproperty
  a_r5: assert property (p_r5) else $error("answer sent in sync mode"); // R5
  property p_r6;
    o_sda_out == 1'b0;
  endproperty
  a_r6: assert property (p_r6) else $error("data line driven high"); // R6
  property p_r2;
    $changed(s_oe_q) |-> $past(scl_fall || cond_start || cond_stop || !sync_m);
  endproperty
  a_r2: assert property (p_r2) else $error("output moved off clock fall"); // R2
  property p_r12;
    cond_start && sync_m |=> s_ph_q == smf_pkg::SMF_P_DEV;
  endproperty
  a_r12: assert property (p_r12) else $error("start not taken"); // R12
  property p_r11;
    cond_stop |=> s_ph_q == smf_pkg::SMF_P_IDLE && !s_oe_q;
  endproperty
  a_r11: assert property (p_r11) else $error("stop not taken"); // R11
  property p_r7;
    byte_end && sync_m && !cond_stop && s_ph_q == smf_pkg::SMF_P_DEV
      |=> s_oe_q == $past(dev_hit);
  endproperty
  a_r7: assert property (p_r7) else $error("wrong address answer"); // R7
  property p_r8;
    prog_go |=> busy_q ##1 busy_q;
  endproperty
  a_r8: assert property (p_r8) else $error("programming not started"); // R8
  property p_r9;
    byte_end && sync_m && !cond_stop && s_ph_q == smf_pkg::SMF_P_WR && !zwr
      |=> s_ph_q == smf_pkg::SMF_P_IDLE && !s_oe_q;
  endproperty
  a_r9: assert property (p_r9) else $error("locked zone accepted"); // R9
  property p_r4;
    !i_rst_pad_drv [*3] |-> rstl;
  endproperty
  a_r4: assert property (p_r4) else $error("free reset pin read low"); // R4
  c_atr:  cover property (o_atr_done);
  c_rx:   cover property (o_rx_valid);
  c_prog: cover property (prog_end);
  c_rd:   cover property (ack_end && s_ph_q == smf_pkg::SMF_P_RD && !nack_q);
endmodule // smf_front_end

// [tb/smf_host_model.sv]
// Behavioural host: sync bus master, async reader and reset pin driver.
`timescale 1ns/100ps
module smf_host_model (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_rel,
  output logic      o_rst_drv
);
  logic lk;
  logic lk_run;
  logic scl_q;
  // The carrier first toggles at 133 ns and never stops; once lk_run is set the line follows it, before that it follows scl_q.
  assign o_scl = lk_run ? lk : scl_q;
  // The carrier phase is offset so its edges never meet the core clock.
  initial begin
    lk = 1'b0;
    lk_run = 1'b0;
    scl_q = 1'b1;
    o_sda_rel = 1'b1;
    o_rst_drv = 1'b0;
    #33;
    forever #100 lk = ~lk;
  end
  // One bus bit of 1 us; data only moves while the clock is low.
  task automatic sbit(input logic b, output logic r);
    #250 o_sda_rel = b;
    #250 scl_q = 1'b1;
    #250 r = i_sda;
    #250 scl_q = 1'b0;
  endtask
  // Start condition, also usable as a repeated start.
  task automatic sstart();
    o_sda_rel = 1'b1;
    #250 scl_q = 1'b1;
    #250 o_sda_rel = 1'b0;
    #250 scl_q = 1'b0;
  endtask
  // Stop condition leaves both lines high.
  task automatic sstop();
    #250 o_sda_rel = 1'b0;
    #250 scl_q = 1'b1;
    #250 o_sda_rel = 1'b1;
    #250;
  endtask
  // Eight bits MSB first, then the acknowledge bit driven as h.
  task automatic sbyte(input logic [7:0] b, input logic h,
                       output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) sbit(b[i], r[i]);
    sbit(h, k);
  endtask
  // Async character out: start, data LSB first, even parity, release.
  task automatic atx(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {^d ^ bad, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_sda_rel = f[i];
      repeat (372) @(posedge lk);
    end
    o_sda_rel = 1'b1;
  endtask
  // Async character in, sampled in the middle of each bit time.
  task automatic arx(output logic [9:0] f);
    @(negedge i_sda);
    repeat (186) @(posedge lk);
    f[0] = i_sda;
    for (int i = 1; i < 10; i++) begin
      repeat (372) @(posedge lk);
      f[i] = i_sda;
    end
  endtask
endmodule // smf_host_model

// [tb/smf_front_end_tb_top.sv]
// Self-checking bench of the secure memory front end.
`timescale 1ns/100ps
module smf_front_end_tb_top;
  localparam int          PROG  = 800;
  localparam int          LIMIT = 130000;
  localparam logic [63:0] ATR_V = 64'h96E1_0F00_0000_0000; // Arbitrary.
  logic       mclk = 1'b0;
  logic       rst_n;
  logic       mode;
  logic [3:0] dev;
  logic [3:0] wr_en;
  logic [3:0] rd_en;
  logic       scl, rel, rdrv, oe, sdo, busy, rx_v, rx_p, sda;
  logic [7:0] rx_d;
  logic [7:0] mem [256];
  int         seed, n_errors, total_checks, cycles, rx_cnt, atr_cnt;
  logic       atr_d;
  // Open-drain wire: the pull-up wins unless some party pulls it low.
  assign sda = rel & ~oe;
  smf_front_end #(.PROG_CYCLES(PROG), .ATR_VALUE(ATR_V)) u_dut (
    .i_mclk       (mclk),
    .i_rst_n      (rst_n),
    .i_scl_clk    (scl),
    .i_sda_in     (sda),
    .o_sda_out    (sdo),
    .o_sda_oe     (oe),
    .i_rst_pad    (1'b0),
    .i_rst_pad_drv(rdrv),
    .i_mode_sync  (mode),
    .i_dev_addr   (dev),
    .i_zone_wr_en (wr_en),
    .i_zone_rd_en (rd_en),
    .o_busy       (busy),
    .o_atr_done   (atr_d),
    .o_rx_data    (rx_d),
    .o_rx_valid   (rx_v),
    .o_rx_perr    (rx_p)
  );
  smf_host_model u_host (
    .i_sda    (sda),
    .o_scl    (scl),
    .o_sda_rel(rel),
    .o_rst_drv(rdrv)
  );
  always #12.5 mclk = ~mclk;
  // Cycle budget guards against a hang; receive pulses are counted.
  always @(posedge mclk) begin
    cycles++;
    if (rx_v === 1'b1) rx_cnt++;
    if (atr_d !== 1'b0) atr_cnt++;
    if (cycles == LIMIT) begin
      n_errors++;
      summarize();
    end
  end
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    return rd_en[a[7:6]] ? mem[a] : 8'hFF;
  endfunction
  task automatic chk(input string nm, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Core-domain inputs move a fixed 2 ns after the rising edge.
  task automatic drive(input logic m, input logic [3:0] w, r);
    @(posedge mclk);
    #2;
    mode = m;
    wr_en = w;
    rd_en = r;
  endtask
  task automatic point(input logic [3:0] da, input logic [7:0] a,
                       input logic ok);
    logic [7:0] r;
    logic       k;
    u_host.sstart();
    u_host.sbyte({da, 3'($random(seed)), 1'b0}, 1'b1, r, k);
    chk("dev ack", {7'h0, k}, {7'h0, ~ok});
    if (ok) begin
      u_host.sbyte(a, 1'b1, r, k);
      chk("adr ack", {7'h0, k}, 8'h00);
    end
  endtask
  task automatic wr_n(input logic [7:0] a, input int n);
    logic [7:0] d, r;
    logic       k;
    point(dev, a, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      u_host.sbyte(d, 1'b1, r, k);
      chk("wr ack", {7'h0, k}, {7'h0, ~wr_en[a[7:6]]});
      if (wr_en[a[7:6]]) mem[{a[7:4], a[3:0] + 4'(i)}] = d;
    end
    u_host.sstop();
  endtask
  task automatic rd_n(input logic [7:0] a, input int n);
    logic [7:0] r;
    logic       k;
    point(dev, a, 1'b1);
    u_host.sstart();
    u_host.sbyte({dev, 3'($random(seed)), 1'b1}, 1'b1, r, k);
    chk("rd ack", {7'h0, k}, 8'h00);
    for (int i = 0; i < n; i++) begin
      u_host.sbyte(8'hFF, i == n - 1, r, k);
      chk("rd data", r, exp_rd(a + 8'(i)));
    end
    u_host.sstop();
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 2 * PROG && busy !== 1'b0; n++) @(posedge mclk);
    chk("busy end", {7'h0, busy}, 8'h00);
  endtask
  // Main sequence: sync bus first, then the async link.
  initial begin
    logic [7:0] a, d;
    logic [9:0] f;
    logic       bad;
    int         n;
    seed = 32'h4CFB;
    rst_n = 1'b0;
    mode = 1'b1;
    wr_en = 4'hF;
    rd_en = 4'hF;
    dev = 4'($random(seed));
    if (dev == 4'h0) dev = 4'h9;
    repeat (6) @(posedge mclk);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    point(dev ^ 4'h5, 8'h00, 1'b0);
    u_host.sstop();
    $display("test address done");
    for (int z = 0; z < 4; z++) begin
      a = {2'(z), 6'($random(seed))};
      wr_n(a, 1);
      repeat (4) @(posedge mclk);
      chk("busy", {7'h0, busy}, 8'h01);
      if (z == 0) begin
        point(dev, a, 1'b0);
        u_host.sstop();
      end
      wait_idle();
      rd_n(a, 1);
      drive(1'b1, 4'hF, ~(4'h1 << z));
      rd_n(a, 1);
      drive(1'b1, ~(4'h1 << z), 4'hF);
      wr_n(a, 1);
      drive(1'b1, 4'hF, 4'hF);
      rd_n(a, 1);
    end
    $display("test zones done");
    a = {4'($random(seed)), 4'h3};
    wr_n(a, 17);
    wait_idle();
    rd_n({a[7:4], 4'h0}, 16);
    $display("test page done");
    u_host.o_rst_drv = 1'b1;
    #2000 u_host.o_rst_drv = 1'b0;
    n = 0;
    repeat (200) begin
      @(posedge mclk);
      if (oe === 1'b1) n++;
    end
    chk("sync atr", 8'(n), 8'h00);
    chk("sync atr done", 8'(atr_cnt), 8'h00);
    $display("test sync reset done");
    drive(1'b0, 4'hF, 4'hF);
    u_host.lk_run = 1'b1;
    d = 8'($random(seed));
    bad = 1'($random(seed));
    rx_cnt = 0;
    #1000 u_host.atx(d, bad);
    repeat (8) @(posedge mclk);
    chk("rx cnt", 8'(rx_cnt), 8'h01);
    chk("rx data", rx_d, d);
    chk("rx perr", {7'h0, rx_p}, {7'h0, bad});
    $display("test async rx done");
    u_host.o_rst_drv = 1'b1;
    #20000;
    fork
      u_host.arx(f);
      #500 u_host.o_rst_drv = 1'b0;
    join
    chk("atr data", f[8:1], ATR_V[63:56]);
    chk("atr frame", {6'h0, f[9], f[0]}, {6'h0, ^ATR_V[63:56], 1'b0});
    chk("sda out", {7'h0, sdo}, 8'h00);
    u_host.o_rst_drv = 1'b1;
    repeat (20) @(posedge mclk);
    chk("abort", {7'h0, oe}, 8'h00);
    // A cut answer must never report itself as finished.
    chk("atr done", 8'(atr_cnt), 8'h00);
    $display("test atr done");
    summarize();
  end
endmodule // smf_front_end_tb_top
